// ---- bench/i2c_bus_model.sv ----
module i2c_bus_model;
  timeunit 1ns;
  timeprecision 100ps;
  // Lines idle high as if pulled up; clock stands still between frames
  logic scl = 1'b1;
  logic sda = 1'b1;

  // ****************************************
  // Bus conditions and bits, 160 ns per bit
  // ****************************************
  task start;
    sda = 1'b1;
    #40 scl = 1'b1;
    #80 sda = 1'b0;
    #80 scl = 1'b0;
    #40;
  endtask : start

  task stop;
    sda = 1'b0;
    #40 scl = 1'b1;
    #80 sda = 1'b1;
    #80;
  endtask : stop

  task bits(input logic [7:0] d, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sda = d[i];
      #40 scl = 1'b1;
      #80 scl = 1'b0;
      #40;
    end
  endtask : bits
endmodule : i2c_bus_model

// ---- bench/i2c_status_flag_logic_test.sv ----
module i2c_status_flag_logic_test
  import i2c_status_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  reg_req_t    req = '0;
  addr_event_t ev = '0;
  logic        mm = 1'b0;
  logic        sm = 1'b0;
  logic        mrx = 1'b0;
  logic [31:0] rdata;
  logic [31:0] st;
  logic [7:0]  txb;
  logic [31:0] d;
  logic [7:0]  b0;
  logic [7:0]  b1;
  int          num_errors = 0;
  int          cmp_count = 0;

  i2c_bus_model u_i2c_bus_model();
  i2c_status_flag_logic u_i2c_status_flag_logic(.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .serial_clock_line_in(u_i2c_bus_model.scl),
    .serial_data_line_in(u_i2c_bus_model.sda), .master_mode_in(mm), .slave_mode_in(sm),
    .master_rx_enable_in(mrx), .addr_event_in(ev), .status_out(st), .tx_byte_out(txb));

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // ****************************************
  // Checking and register access
  // ****************************************
  function automatic logic rw_of(input logic [7:0] a);
    return a[0];
  endfunction : rw_of

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Waits out synchroniser and status latency before looking
  task flag(input int p, input logic e);
    #150 chk({31'h0, st[p]}, {31'h0, e});
  endtask : flag

  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_in);
    req <= {a, v, 1'b1, 1'b0};
    @(posedge clk_in);
    req <= '0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_in);
    req <= {a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk_in);
    req <= '0;
    #1 v = rdata;
  endtask : rd

  task pulse(input addr_event_t e);
    @(posedge clk_in);
    ev <= e;
    @(posedge clk_in);
    ev <= '0;
  endtask : pulse

  task complete_run;
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    #200000 num_errors++;
    complete_run();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    b0 = 8'($urandom(32'hd299));
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(STATUS_OFFSET, d);
    chk(d, STATUS_RESET);
    rd(4'hc, d);
    chk(d, 32'h0);
    sm <= 1'b1;
    u_i2c_bus_model.start();
    flag(START_SEEN_POS, 1'b1);
    flag(STOP_SEEN_POS, 1'b0);
    u_i2c_bus_model.bits(8'h42, 8);
    // Event bits in order: address match, general call, ten-bit match
    pulse(3'h4);
    flag(ACK_WINDOW_POS, 1'b1);
    flag(READ_WRITE_POS, rw_of(8'h42));
    flag(DATA_ADDR_POS, 1'b0);
    flag(RX_FULL_POS, 1'b1);
    u_i2c_bus_model.bits(8'h00, 1);
    flag(ACK_WINDOW_POS, 1'b0);
    rd(RX_OFFSET, d);
    chk(d, 32'h42);
    flag(RX_FULL_POS, 1'b0);
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    u_i2c_bus_model.bits(b0, 8);
    u_i2c_bus_model.bits(8'h00, 1);
    flag(DATA_ADDR_POS, 1'b1);
    u_i2c_bus_model.bits(b1, 8);
    flag(ACK_WINDOW_POS, 1'b1);
    wr(STATUS_OFFSET, 32'h0000_2000);
    flag(ACK_WINDOW_POS, 1'b0);
    u_i2c_bus_model.bits(8'h00, 1);
    flag(RX_OVERFLOW_POS, 1'b1);
    rd(RX_OFFSET, d);
    chk(d, {24'h0, b0});
    wr(STATUS_OFFSET, 32'h40);
    flag(RX_OVERFLOW_POS, 1'b0);
    pulse(3'h2);
    pulse(3'h1);
    flag(GEN_CALL_POS, 1'b1);
    flag(TEN_BIT_POS, 1'b1);
    u_i2c_bus_model.start();
    u_i2c_bus_model.bits(8'h43, 8);
    flag(READ_WRITE_POS, rw_of(8'h43));
    pulse(3'h4);
    flag(DATA_ADDR_POS, 1'b0);
    u_i2c_bus_model.bits(8'h01, 1);
    u_i2c_bus_model.stop();
    flag(STOP_SEEN_POS, 1'b1);
    flag(START_SEEN_POS, 1'b0);
    flag(GEN_CALL_POS, 1'b0);
    flag(TEN_BIT_POS, 1'b0);
    wr(STATUS_OFFSET, 32'h0000_0010);
    flag(STOP_SEEN_POS, 1'b0);
    sm <= 1'b0;
    mm <= 1'b1;
    u_i2c_bus_model.start();
    wr(TX_OFFSET, 32'ha5);
    flag(TX_FULL_POS, 1'b1);
    flag(TX_ACTIVE_POS, 1'b1);
    wr(TX_OFFSET, 32'h5a);
    flag(WRITE_COLL_POS, 1'b1);
    chk({24'h0, txb}, 32'ha5);
    u_i2c_bus_model.bits(8'ha5, 8);
    u_i2c_bus_model.bits(8'h01, 1);
    flag(ACK_RESULT_POS, 1'b1);
    flag(TX_ACTIVE_POS, 1'b0);
    flag(TX_FULL_POS, 1'b0);
    wr(TX_OFFSET, 32'h80);
    u_i2c_bus_model.bits(8'h00, 8);
    flag(BUS_COLL_POS, 1'b1);
    u_i2c_bus_model.bits(8'h00, 1);
    flag(ACK_RESULT_POS, 1'b0);
    wr(STATUS_OFFSET, 32'h0480);
    flag(BUS_COLL_POS, 1'b0);
    flag(WRITE_COLL_POS, 1'b0);
    rd(RX_OFFSET, d);
    chk(d, 32'h43);
    // Master receive: completed byte goes to the receive register
    mrx <= 1'b1;
    b1 = 8'($urandom);
    u_i2c_bus_model.bits(b1, 8);
    flag(RX_FULL_POS, 1'b1);
    rd(RX_OFFSET, d);
    chk(d, {24'h0, b1});
    mrx <= 1'b0;
    rd(STATUS_OFFSET, d);
    chk(d & ~STATUS_IMPL_MASK, 32'h0);
    u_i2c_bus_model.stop();
    complete_run();
  end
endmodule : i2c_status_flag_logic_test

// ---- hw/bus_condition.sv ----
module bus_condition
  import i2c_status_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  // Filtered bus lines
  input  wire logic scl_level_in,
  input  wire logic sda_rise_in,
  input  wire logic sda_fall_in,
  // Detected conditions, one-cycle pulses
  output bus_cond_t cond_out
);

  bus_cond_t next_cond;

  // Data moving while the clock is high marks a frame boundary
  assign next_cond = '{start: scl_level_in & sda_fall_in, stop: scl_level_in & sda_rise_in};

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cond_out <= '0;
    end else begin
      cond_out <= next_cond;
    end
  end

endmodule : bus_condition

// ---- hw/i2c_status_flag_logic.sv ----
// Behaviour
// - In master transmit the acknowledge result flag takes 1 for NACK and 0 for ACK at the end of the acknowledge.
// - The master transmit flag rises when a master transmission begins and falls when the acknowledge ends.
// - In slave mode the acknowledge window flag sets on the 8th falling clock edge, clears on the 9th rising one.
// - The bus collision flag sets on a collision during a master transmission and stays until software clears it.
// - The general call flag sets on a general call address match and clears on a Stop.
// - The ten-bit match flag sets on a match of the second address byte and clears on a Stop.
// - A transmit write while busy is dropped and sets the write collision flag, cleared only by software.
// - A byte completed in slave receive or master receive meeting a full receive register sets the overflow flag, cleared by software.
// - In slave mode the data/address flag clears on an address match and sets on a received data byte.
// - The stop flag reads 1 after a Stop, 0 after a Start or Repeated Start, and software may clear it.
// - The start flag reads 1 after a Start or Repeated Start, 0 after a Stop, and software may clear it.
// - In slave mode the direction flag takes the last address bit: 1 for read, 0 for write.
// - The receive full flag sets when a byte is loaded and clears when software reads the receive register.
// - The transmit full flag sets on a software transmit write and clears when that transmission completes.
// - Status bits 31 to 16 and 12 to 11 always read as zero.
module i2c_status_flag_logic
  import i2c_status_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  // Register port
  input  wire reg_req_t     reg_req_in,
  output logic [31:0]       reg_rdata_out,
  // Bus lines, asynchronous
  input  wire logic         serial_clock_line_in,
  input  wire logic         serial_data_line_in,
  // Control sequencer and address matcher
  input  wire logic         master_mode_in,
  input  wire logic         slave_mode_in,
  input  wire logic         master_rx_enable_in,
  input  wire addr_event_t  addr_event_in,
  // Status and data towards the port
  output logic [31:0]       status_out,
  output logic [7:0]        tx_byte_out
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic set_clr(input logic flag, input logic set, input logic clr);
    set_clr = set | (flag & ~clr);
  endfunction : set_clr

  // ****************************************
  // Line sampling
  // ****************************************
  logic      scl;
  logic      scl_rise;
  logic      scl_fall;
  logic      sda;
  logic      sda_rise;
  logic      sda_fall;
  bus_cond_t cond;

  line_sync #(
    .RESET_LEVEL (LINE_IDLE)
  ) u_scl_sync (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .line_in   (serial_clock_line_in),
    .level_out (scl),
    .rise_out  (scl_rise),
    .fall_out  (scl_fall)
  );

  line_sync #(
    .RESET_LEVEL (LINE_IDLE)
  ) u_sda_sync (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .line_in   (serial_data_line_in),
    .level_out (sda),
    .rise_out  (sda_rise),
    .fall_out  (sda_fall)
  );

  bus_condition u_bus_condition (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .scl_level_in (scl),
    .sda_rise_in  (sda_rise),
    .sda_fall_in  (sda_fall),
    .cond_out     (cond)
  );

  // ****************************************
  // State
  // ****************************************
  logic [3:0] bit_cnt;
  logic       first_byte;
  logic       ack_sample;
  logic [7:0] rx_shift_reg;
  logic [7:0] rx_holding_reg;
  logic [7:0] tx_holding_reg;

  logic ack_result_flag;
  logic master_tx_active;
  logic ack_window_flag;
  logic bus_collision_flag;
  logic general_call_seen;
  logic ten_bit_match_flag;
  logic write_collision_flag;
  logic rx_overflow_flag;
  logic data_addr_flag;
  logic stop_seen;
  logic start_seen;
  logic read_write_flag;
  logic rx_full_flag;
  logic tx_full_flag;

  // ****************************************
  // Bit timing decode
  // ****************************************
  logic       byte_done;
  logic       ack_win_set;
  logic       ack_win_clr;
  logic       ack_end;
  logic [7:0] new_byte;
  logic [2:0] tx_bit_idx;
  logic       tx_bit;
  logic       collision;

  assign byte_done   = scl_rise & (bit_cnt == DATA_BITS - 4'h1);
  assign ack_win_set = slave_mode_in & scl_fall & (bit_cnt == DATA_BITS);
  assign ack_win_clr = scl_rise & (bit_cnt == DATA_BITS);
  assign ack_end     = scl_fall & (bit_cnt == ACK_BIT_COUNT);
  assign new_byte    = {rx_shift_reg[6:0], sda};
  assign tx_bit_idx  = 3'h7 - bit_cnt[2:0];
  assign tx_bit      = tx_holding_reg[tx_bit_idx];
  // Released high but read low while we own the data line
  assign collision   = master_tx_active & scl_rise & (bit_cnt < DATA_BITS) & tx_bit & ~sda;

  // ****************************************
  // Register port decode
  // ****************************************
  logic        status_wr;
  logic        tx_write;
  logic        rx_read;
  logic        busy;
  logic        tx_accept;
  logic        wcol_set;
  logic [31:0] clr_mask;

  assign status_wr = reg_req_in.wr & (reg_req_in.addr == STATUS_OFFSET);
  assign tx_write  = reg_req_in.wr & (reg_req_in.addr == TX_OFFSET);
  assign rx_read   = reg_req_in.rd & (reg_req_in.addr == RX_OFFSET);
  assign busy      = tx_full_flag | master_tx_active;
  assign tx_accept = tx_write & ~busy;
  assign wcol_set  = tx_write & busy;
  // Clearable flags are cleared by writing a one to their position
  assign clr_mask  = status_wr ? reg_req_in.wdata : 32'h0000_0000;

  // ****************************************
  // Receive path decode
  // ****************************************
  logic slave_rx;
  logic rx_capture;
  logic rx_load;
  logic overflow_set;
  logic slave_addr_byte;
  logic slave_data_byte;

  assign slave_rx        = slave_mode_in & (first_byte | ~read_write_flag);
  assign rx_capture      = byte_done & (slave_rx | master_rx_enable_in);
  assign rx_load         = rx_capture & ~rx_full_flag;
  assign overflow_set    = rx_capture & rx_full_flag;
  assign slave_addr_byte = slave_mode_in & byte_done & first_byte;
  assign slave_data_byte = slave_mode_in & byte_done & ~first_byte;

  // ****************************************
  // Bit counter and shifter
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      bit_cnt    <= 4'h0;
      first_byte <= 1'b1;
    end else if (cond.start | cond.stop) begin
      bit_cnt    <= 4'h0;
      first_byte <= 1'b1;
    end else if (ack_end) begin
      bit_cnt    <= 4'h0;
      first_byte <= 1'b0;
    end else if (scl_rise && bit_cnt < ACK_BIT_COUNT) begin
      bit_cnt    <= bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rx_shift_reg <= BYTE_RESET;
      ack_sample   <= 1'b0;
    end else if (scl_rise) begin
      if (bit_cnt < DATA_BITS) begin
        rx_shift_reg <= new_byte;
      end
      if (bit_cnt == DATA_BITS) begin
        ack_sample <= sda;
      end
    end
  end

  // ****************************************
  // Holding registers
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rx_holding_reg <= BYTE_RESET;
      tx_holding_reg <= BYTE_RESET;
    end else begin
      // The previous byte is kept on overflow
      if (rx_load) begin
        rx_holding_reg <= new_byte;
      end
      if (tx_accept) begin
        tx_holding_reg <= reg_req_in.wdata[7:0];
      end
    end
  end

  // ****************************************
  // Transfer flags
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ack_result_flag  <= 1'b0;
      master_tx_active <= 1'b0;
      tx_full_flag     <= 1'b0;
      rx_full_flag     <= 1'b0;
      read_write_flag  <= 1'b0;
      data_addr_flag   <= 1'b0;
    end else begin
      if (ack_end && master_tx_active) begin
        ack_result_flag <= ack_sample;
      end
      master_tx_active <= set_clr(master_tx_active, tx_accept & master_mode_in, ack_end);
      tx_full_flag     <= set_clr(tx_full_flag, tx_accept, ack_end);
      rx_full_flag     <= set_clr(rx_full_flag, rx_load, rx_read);
      if (slave_addr_byte) begin
        read_write_flag <= sda;
      end
      // An address match outranks a data byte finishing in the same cycle
      if (addr_event_in.addr_match) begin
        data_addr_flag <= 1'b0;
      end else if (slave_data_byte) begin
        data_addr_flag <= 1'b1;
      end
    end
  end

  // ****************************************
  // Event flags
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ack_window_flag      <= 1'b0;
      bus_collision_flag   <= 1'b0;
      general_call_seen    <= 1'b0;
      ten_bit_match_flag   <= 1'b0;
      write_collision_flag <= 1'b0;
      rx_overflow_flag     <= 1'b0;
      stop_seen            <= 1'b0;
      start_seen           <= 1'b0;
    end else begin
      ack_window_flag      <= set_clr(ack_window_flag, ack_win_set,
                                      ack_win_clr | clr_mask[ACK_WINDOW_POS]);
      bus_collision_flag   <= set_clr(bus_collision_flag, collision, clr_mask[BUS_COLL_POS]);
      general_call_seen    <= set_clr(general_call_seen, addr_event_in.gc_match, cond.stop);
      ten_bit_match_flag   <= set_clr(ten_bit_match_flag, addr_event_in.ten_bit_match, cond.stop);
      write_collision_flag <= set_clr(write_collision_flag, wcol_set, clr_mask[WRITE_COLL_POS]);
      rx_overflow_flag     <= set_clr(rx_overflow_flag, overflow_set, clr_mask[RX_OVERFLOW_POS]);
      stop_seen            <= set_clr(stop_seen, cond.stop, cond.start | clr_mask[STOP_SEEN_POS]);
      start_seen           <= set_clr(start_seen, cond.start, cond.stop | clr_mask[START_SEEN_POS]);
    end
  end

  // ****************************************
  // Status word and read port
  // ****************************************
  logic [31:0] status_word;
  logic [31:0] next_rdata;

  // Unlisted positions stay zero
  always_comb begin
    status_word                  = STATUS_RESET;
    status_word[ACK_RESULT_POS]  = ack_result_flag;
    status_word[TX_ACTIVE_POS]   = master_tx_active;
    status_word[ACK_WINDOW_POS]  = ack_window_flag;
    status_word[BUS_COLL_POS]    = bus_collision_flag;
    status_word[GEN_CALL_POS]    = general_call_seen;
    status_word[TEN_BIT_POS]     = ten_bit_match_flag;
    status_word[WRITE_COLL_POS]  = write_collision_flag;
    status_word[RX_OVERFLOW_POS] = rx_overflow_flag;
    status_word[DATA_ADDR_POS]   = data_addr_flag;
    status_word[STOP_SEEN_POS]   = stop_seen;
    status_word[START_SEEN_POS]  = start_seen;
    status_word[READ_WRITE_POS]  = read_write_flag;
    status_word[RX_FULL_POS]     = rx_full_flag;
    status_word[TX_FULL_POS]     = tx_full_flag;
  end

  assign next_rdata = !reg_req_in.rd                   ? 32'h0000_0000 :
                      (reg_req_in.addr == STATUS_OFFSET) ? status_word :
                      (reg_req_in.addr == RX_OFFSET)     ? {24'h00_0000, rx_holding_reg} :
                      (reg_req_in.addr == TX_OFFSET)     ? {24'h00_0000, tx_holding_reg} :
                                                          32'h0000_0000;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 32'h0000_0000;
      status_out    <= STATUS_RESET;
      tx_byte_out   <= BYTE_RESET;
    end else begin
      reg_rdata_out <= next_rdata;
      status_out    <= status_word;
      tx_byte_out   <= tx_holding_reg;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  ack_result_upd_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (ack_end && master_tx_active) |=> (ack_result_flag == $past(ack_sample)))
    else $error("acknowledge result not taken at end of acknowledge");

  tx_active_span_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ((tx_accept && master_mode_in) || (master_tx_active && !ack_end)) |=> master_tx_active)
    else $error("master transmit flag dropped before acknowledge end");

  tx_active_end_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (ack_end && !(tx_accept && master_mode_in)) |=> !master_tx_active)
    else $error("master transmit flag held past acknowledge end");

  ack_window_set_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ack_win_set |=> ack_window_flag)
    else $error("acknowledge window not opened on eighth falling edge");

  ack_window_clr_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ack_win_clr |=> !ack_window_flag)
    else $error("acknowledge window not closed on ninth rising edge");

  collision_sticky_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (bus_collision_flag && !clr_mask[BUS_COLL_POS]) |=> bus_collision_flag)
    else $error("bus collision flag lost without software clear");

  general_call_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (cond.stop && !addr_event_in.gc_match) |=> !general_call_seen)
    else $error("general call flag survived a stop");

  ten_bit_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    addr_event_in.ten_bit_match |=> ten_bit_match_flag)
    else $error("ten-bit match flag not set");

  write_coll_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    wcol_set |=> (write_collision_flag && tx_holding_reg == $past(tx_holding_reg)))
    else $error("busy transmit write not refused");

  rx_overflow_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    overflow_set |=> (rx_overflow_flag && rx_holding_reg == $past(rx_holding_reg)))
    else $error("overflow not flagged or held byte overwritten");

  data_addr_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    addr_event_in.addr_match |=> !data_addr_flag)
    else $error("data/address flag not cleared on address match");

  stop_start_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    cond.stop |=> (stop_seen && !start_seen))
    else $error("stop condition not reflected in flags");

  start_stop_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    cond.start |=> (start_seen && !stop_seen))
    else $error("start condition not reflected in flags");

  direction_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    slave_addr_byte |=> (read_write_flag == $past(sda)))
    else $error("direction flag not taken from address byte");

  rx_full_read_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (rx_read && !rx_load) |=> !rx_full_flag)
    else $error("receive full flag not cleared by read");

  tx_full_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    tx_accept |=> (tx_full_flag && tx_holding_reg == $past(reg_req_in.wdata[7:0])))
    else $error("transmit full flag not set on write");

  unimplemented_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (status_out & ~STATUS_IMPL_MASK) == 32'h0000_0000)
    else $error("unimplemented status bits read nonzero");

endmodule : i2c_status_flag_logic

// ---- hw/i2c_status_pkg.sv ----
package i2c_status_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned REG_ADDR_W    = 4;
  localparam logic [3:0]  STATUS_OFFSET = 4'h0;
  localparam logic [3:0]  TX_OFFSET     = 4'h4;
  localparam logic [3:0]  RX_OFFSET     = 4'h8;

  // ****************************************
  // Status field positions
  // ****************************************
  localparam int unsigned ACK_RESULT_POS  = 15;
  localparam int unsigned TX_ACTIVE_POS   = 14;
  localparam int unsigned ACK_WINDOW_POS  = 13;
  localparam int unsigned BUS_COLL_POS    = 10;
  localparam int unsigned GEN_CALL_POS    = 9;
  localparam int unsigned TEN_BIT_POS     = 8;
  localparam int unsigned WRITE_COLL_POS  = 7;
  localparam int unsigned RX_OVERFLOW_POS = 6;
  localparam int unsigned DATA_ADDR_POS   = 5;
  localparam int unsigned STOP_SEEN_POS   = 4;
  localparam int unsigned START_SEEN_POS  = 3;
  localparam int unsigned READ_WRITE_POS  = 2;
  localparam int unsigned RX_FULL_POS     = 1;
  localparam int unsigned TX_FULL_POS     = 0;

  // ****************************************
  // Reset values, masks and counts
  // ****************************************
  localparam logic [31:0] STATUS_RESET     = 32'h0000_0000;
  localparam logic [31:0] STATUS_IMPL_MASK = 32'h0000_e7ff;
  localparam logic [7:0]  BYTE_RESET       = 8'h00;
  localparam logic [3:0]  DATA_BITS        = 4'h8;
  localparam logic [3:0]  ACK_BIT_COUNT    = 4'h9;
  localparam logic        LINE_IDLE        = 1'b1;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [REG_ADDR_W-1:0] addr;
    logic [31:0]           wdata;
    logic                  wr;
    logic                  rd;
  } reg_req_t;

  typedef struct packed {
    logic addr_match;
    logic gc_match;
    logic ten_bit_match;
  } addr_event_t;

  typedef struct packed {
    logic start;
    logic stop;
  } bus_cond_t;

endpackage : i2c_status_pkg

// ---- hw/line_sync.sv ----
module line_sync
  import i2c_status_pkg::*;
#(
  parameter logic RESET_LEVEL = LINE_IDLE
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  // Asynchronous line
  input  wire logic line_in,
  // Filtered level and edges
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);

  logic [2:0] stages;
  logic       agree;
  logic       next_level;

  // A change counts only once the second and third stages agree
  assign agree      = (stages[1] == stages[2]);
  assign next_level = agree ? stages[2] : level_out;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      stages    <= {3{RESET_LEVEL}};
      level_out <= RESET_LEVEL;
      rise_out  <= 1'b0;
      fall_out  <= 1'b0;
    end else begin
      stages    <= {stages[1:0], line_in};
      level_out <= next_level;
      rise_out  <= next_level & ~level_out;
      fall_out  <= ~next_level & level_out;
    end
  end

endmodule : line_sync
